// ---- rtl/flash_ctrl_pkg.sv ----
// Package: register map, field positions, states and carrier structs for the flash control block
package flash_ctrl_pkg;
  localparam int NUM_BANKS = 2;
  localparam int BANK_W = 1;
  // Register byte offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COMMAND = 8'h08;
  localparam logic [7:0] ADDR_PROTECT = 8'h0c;
  localparam logic [7:0] ADDR_SECURITY = 8'h10;
  localparam logic [7:0] ADDR_ARRAY = 8'h14;
  localparam logic [7:0] ADDR_ARRAY_DATA = 8'h18;
  // Config register fields
  localparam int CFG_BANK = 0;
  localparam int CFG_KEY_ACCESS_BIT = 4;
  localparam int CFG_COMPLETE_IRQ_EN = 6;
  localparam int CFG_BUFFERS_EMPTY_IRQ_EN = 7;
  // Status register fields
  localparam int ST_ACCESS_ERROR_FLAG = 4;
  localparam int ST_PROTECTION_VIOLATION_FLAG = 5;
  localparam int ST_CMD_COMPLETE_FLAG = 6;
  localparam int ST_BUFFERS_EMPTY_FLAG = 7;
  // Security register fields
  localparam int SEC_BACKDOOR_ENABLE_LO = 6;
  localparam logic [1:0] SEC_UNSECURED = 2'b10;
  localparam logic [1:0] BACKDOOR_ENABLE_ON = 2'b10;
  // Backdoor key addresses in flash word space
  localparam logic [15:0] KEY_BASE = 16'hff00;
  localparam logic [15:0] KEY_LAST = 16'hff06;
  localparam logic [15:0] SEC_BYTE_ADDR = 16'hff0f;
  // Commands
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'h05;
  localparam logic [7:0] CMD_PROGRAM = 8'h20;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h40;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
  localparam logic [7:0] PROT_RESET = 8'hff;
  localparam logic [31:0] INVALID_DATA = 32'hffffffff;
  // Command engine duration in cycles
  localparam logic [7:0] CMD_CYCLES = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ENG_IDLE = 4'b0001,
    ENG_BUSY = 4'b0010,
    ENG_STOP = 4'b0100,
    ENG_LOAD = 4'b1000
  } eng_state_t;

  typedef struct packed {
    logic buffers_empty_flag;
    logic cmd_complete_flag;
    logic protection_violation_flag;
    logic access_error_flag;
    logic armed;
    logic queued;
    logic [7:0] cmd;
  } bank_t;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bus_t;

  typedef struct packed {
    eng_state_t eng;
    logic [7:0] timer;
    logic [BANK_W-1:0] run_bank;
    bus_t bus;
    bank_t [NUM_BANKS-1:0] bank;
    logic [BANK_W-1:0] bank_sel;
    logic key_access;
    logic complete_irq_en;
    logic buffers_empty_irq_en;
    logic [7:0] prot;
    logic [1:0] security_field;
    logic [1:0] backdoor_enable;
    logic [1:0] key_idx;
    logic key_ok;
    logic [2:0] stop_sync;
    logic stop_q;
    logic irq;
  } state_t;
endpackage : flash_ctrl_pkg

// ---- rtl/flash_stop_security_irq_ctrl.sv ----
// Flash control: stop abort, debug privileges, security, backdoor key, interrupts
`timescale 1ns/1ps
module flash_stop_security_irq_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stop_req,
  input wire logic background_debug_mode,
  input wire logic special_single_chip,
  input wire logic [7:0] stored_security_byte,
  input wire logic [63:0] stored_key,
  output logic chip_secured,
  output logic flash_irq
);
  // Package sizes given local names; declared before any process reads them
  localparam int NUM_BANKS_L = flash_ctrl_pkg::NUM_BANKS;
  localparam int BANK_W = flash_ctrl_pkg::BANK_W;

  flash_ctrl_pkg::state_t s_reg;
  flash_ctrl_pkg::state_t s_next;

  // Word of the stored key selected by index
  function automatic logic [15:0] key_word(input logic [63:0] k, input logic [1:0] i);
    key_word = k[16*i +: 16];
  endfunction : key_word

  // Any bank holding a locking error flag
  function automatic logic any_error(input flash_ctrl_pkg::bank_t [1:0] b);
    any_error = b[0].access_error_flag | b[0].protection_violation_flag | b[1].access_error_flag | b[1].protection_violation_flag;
  endfunction : any_error

  logic wr_fire;
  logic rd_fire;
  logic secured_now;
  logic stop_level;
  logic [15:0] arr_addr;
  logic [7:0] wcmd;
  logic cmd_legal;
  logic [7:0] status_byte;

  // Ready only while no response is outstanding; both channels taken in any order
  assign s_axi_awready = !s_reg.bus.aw_got && !s_reg.bus.bvalid;
  assign s_axi_wready = !s_reg.bus.w_got && !s_reg.bus.bvalid;
  assign s_axi_arready = !s_reg.bus.rvalid;
  assign s_axi_bvalid = s_reg.bus.bvalid;
  assign s_axi_bresp = s_reg.bus.bresp;
  assign s_axi_rvalid = s_reg.bus.rvalid;
  assign s_axi_rdata = s_reg.bus.rdata;
  assign s_axi_rresp = s_reg.bus.rresp;
  assign chip_secured = s_reg.security_field != flash_ctrl_pkg::SEC_UNSECURED;
  assign flash_irq = s_reg.irq;

  assign secured_now = s_reg.security_field != flash_ctrl_pkg::SEC_UNSECURED;
  // Stop arrives from the power controller, so filter it through three stages
  assign stop_level = s_reg.stop_sync[2] & s_reg.stop_sync[1];
  assign wr_fire = (s_reg.bus.aw_got | (s_axi_awvalid & s_axi_awready))
    & (s_reg.bus.w_got | (s_axi_wvalid & s_axi_wready)) & !s_reg.bus.bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign status_byte = {s_reg.bank[s_reg.bank_sel].buffers_empty_flag, s_reg.bank[s_reg.bank_sel].cmd_complete_flag,
    s_reg.bank[s_reg.bank_sel].protection_violation_flag, s_reg.bank[s_reg.bank_sel].access_error_flag, 4'h0};

  // Command privilege: debug unsecured takes all, secured special mode only mass erase
  always_comb begin
    wcmd = 8'h00;
    cmd_legal = 1'b0;
    arr_addr = 16'h0000;
    if (s_reg.bus.w_got) begin
      wcmd = s_reg.bus.wdata[7:0];
      arr_addr = s_reg.bus.wdata[31:16];
    end else begin
      wcmd = s_axi_wdata[7:0];
      arr_addr = s_axi_wdata[31:16];
    end
    if (wcmd == flash_ctrl_pkg::CMD_ERASE_VERIFY || wcmd == flash_ctrl_pkg::CMD_PROGRAM ||
        wcmd == flash_ctrl_pkg::CMD_SECTOR_ERASE || wcmd == flash_ctrl_pkg::CMD_MASS_ERASE) begin
      cmd_legal = 1'b1;
    end
    if (secured_now && special_single_chip && wcmd != flash_ctrl_pkg::CMD_MASS_ERASE) begin
      cmd_legal = 1'b0;
    end
  end

  always_comb begin
    logic [7:0] waddr;
    logic [31:0] wd;
    logic [BANK_W-1:0] bs;
    logic launch_ok;
    waddr = 8'h00;
    wd = 32'h0;
    bs = '0;
    launch_ok = 1'b0;
    s_next = s_reg;
    s_next.stop_sync = {s_reg.stop_sync[1:0], stop_req};
    if (s_reg.stop_sync[2] == s_reg.stop_sync[1]) begin
      s_next.stop_q = stop_level;
    end
    waddr = s_reg.bus.aw_got ? s_reg.bus.awaddr : s_axi_awaddr;
    wd = s_reg.bus.w_got ? s_reg.bus.wdata : s_axi_wdata;
    bs = s_reg.bank_sel;

    // Command engine; stop entry and exit override normal progress
    case (s_reg.eng)
      flash_ctrl_pkg::ENG_IDLE: begin
        if (s_reg.stop_q) begin
          s_next.eng = flash_ctrl_pkg::ENG_STOP;
        end else if (s_reg.bank[s_reg.run_bank].queued) begin
          s_next.eng = flash_ctrl_pkg::ENG_BUSY;
          s_next.timer = flash_ctrl_pkg::CMD_CYCLES;
          s_next.bank[s_reg.run_bank].queued = 1'b0;
        end
      end
      flash_ctrl_pkg::ENG_BUSY: begin
        if (s_reg.stop_q) begin
          // Abort mid-operation; every bank with work gets both flags
          for (int i = 0; i < NUM_BANKS_L; i++) begin
            if (!s_reg.bank[i].cmd_complete_flag) begin
              s_next.bank[i].cmd_complete_flag = 1'b1;
              s_next.bank[i].access_error_flag = 1'b1;
            end
          end
          s_next.eng = flash_ctrl_pkg::ENG_STOP;
        end else if (s_reg.timer > 8'h01) begin
          s_next.timer = s_reg.timer - 8'h01;
        end else if (s_reg.bank[s_reg.run_bank].queued) begin
          s_next.timer = flash_ctrl_pkg::CMD_CYCLES;
          s_next.bank[s_reg.run_bank].queued = 1'b0;
        end else begin
          s_next.bank[s_reg.run_bank].cmd_complete_flag = 1'b1;
          s_next.eng = flash_ctrl_pkg::ENG_IDLE;
        end
      end
      flash_ctrl_pkg::ENG_STOP: begin
        if (!s_reg.stop_q) begin
          for (int i = 0; i < NUM_BANKS_L; i++) begin
            s_next.bank[i].buffers_empty_flag = 1'b1;
            s_next.bank[i].queued = 1'b0;
            s_next.bank[i].armed = 1'b0;
          end
          s_next.eng = flash_ctrl_pkg::ENG_IDLE;
        end
      end
      flash_ctrl_pkg::ENG_LOAD: begin
        s_next.eng = flash_ctrl_pkg::ENG_IDLE;
      end
      default: begin
        s_next.eng = flash_ctrl_pkg::ENG_IDLE;
      end
    endcase

    // Write channels
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.bus.aw_got = 1'b1;
      s_next.bus.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.bus.w_got = 1'b1;
      s_next.bus.wdata = s_axi_wdata;
      s_next.bus.wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      s_next.bus.aw_got = 1'b0;
      s_next.bus.w_got = 1'b0;
      s_next.bus.bvalid = 1'b1;
      s_next.bus.bresp = flash_ctrl_pkg::RESP_OKAY;
      case (waddr)
        flash_ctrl_pkg::ADDR_CONFIG: begin
          s_next.bank_sel = wd[flash_ctrl_pkg::CFG_BANK +: BANK_W];
          s_next.complete_irq_en = wd[flash_ctrl_pkg::CFG_COMPLETE_IRQ_EN];
          s_next.buffers_empty_irq_en = wd[flash_ctrl_pkg::CFG_BUFFERS_EMPTY_IRQ_EN];
          s_next.key_access = wd[flash_ctrl_pkg::CFG_KEY_ACCESS_BIT];
          if (wd[flash_ctrl_pkg::CFG_KEY_ACCESS_BIT] && !s_reg.key_access) begin
            s_next.key_idx = 2'b00;
            s_next.key_ok = 1'b1;
          end
        end
        flash_ctrl_pkg::ADDR_STATUS: begin
          // Write one clears error flags; set in the same cycle by the engine wins
          if (wd[flash_ctrl_pkg::ST_ACCESS_ERROR_FLAG] && s_next.bank[bs].access_error_flag == s_reg.bank[bs].access_error_flag) begin
            s_next.bank[bs].access_error_flag = 1'b0;
          end
          if (wd[flash_ctrl_pkg::ST_PROTECTION_VIOLATION_FLAG]) begin
            s_next.bank[bs].protection_violation_flag = 1'b0;
          end
          if (!wd[flash_ctrl_pkg::ST_BUFFERS_EMPTY_FLAG]) begin
            s_next.bank[bs].access_error_flag = 1'b1;
            s_next.bank[bs].armed = 1'b0;
          end else if (s_reg.bank[bs].armed && s_reg.bank[bs].buffers_empty_flag) begin
            launch_ok = !any_error(s_reg.bank) && !s_reg.stop_q;
            if (launch_ok) begin
              s_next.bank[bs].queued = 1'b1;
              s_next.bank[bs].cmd_complete_flag = 1'b0;
              s_next.bank[bs].armed = 1'b0;
              s_next.run_bank = bs;
            end else begin
              s_next.bank[bs].access_error_flag = 1'b1;
            end
          end
        end
        flash_ctrl_pkg::ADDR_COMMAND: begin
          if (cmd_legal && !any_error(s_reg.bank)) begin
            s_next.bank[bs].cmd = wd[7:0];
            s_next.bank[bs].armed = 1'b1;
          end else begin
            s_next.bank[bs].access_error_flag = 1'b1;
            s_next.bus.bresp = flash_ctrl_pkg::RESP_SLVERR;
          end
        end
        flash_ctrl_pkg::ADDR_PROTECT: begin
          if (background_debug_mode) begin
            s_next.prot = wd[7:0];
          end else begin
            s_next.bus.bresp = flash_ctrl_pkg::RESP_SLVERR;
          end
        end
        flash_ctrl_pkg::ADDR_ARRAY: begin
          // Backdoor compare; word stays untouched in the array
          if (s_reg.key_access && s_reg.backdoor_enable == flash_ctrl_pkg::BACKDOOR_ENABLE_ON) begin
            if (arr_addr == flash_ctrl_pkg::KEY_BASE + {13'h0, s_reg.key_idx, 1'b0}) begin
              if (wd[15:0] != key_word(stored_key, s_reg.key_idx)) begin
                s_next.key_ok = 1'b0;
              end
              if (arr_addr == flash_ctrl_pkg::KEY_LAST) begin
                if (s_next.key_ok && !(background_debug_mode && special_single_chip)) begin
                  s_next.security_field = flash_ctrl_pkg::SEC_UNSECURED;
                end
                s_next.key_ok = 1'b0;
              end else begin
                s_next.key_idx = s_reg.key_idx + 2'b01;
              end
            end else begin
              s_next.key_ok = 1'b0;
            end
          end else if (!s_reg.bank[bs].buffers_empty_flag) begin
            s_next.bank[bs].access_error_flag = 1'b1;
          end
        end
        default: begin
          s_next.bus.bresp = flash_ctrl_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.bus.bvalid && s_axi_bready) begin
      s_next.bus.bvalid = 1'b0;
    end

    // Read channel
    if (rd_fire) begin
      s_next.bus.rvalid = 1'b1;
      s_next.bus.rresp = flash_ctrl_pkg::RESP_OKAY;
      case (s_axi_araddr)
        flash_ctrl_pkg::ADDR_CONFIG: begin
          s_next.bus.rdata = {24'h0, s_reg.buffers_empty_irq_en, s_reg.complete_irq_en, 1'b0, s_reg.key_access,
            3'b000, s_reg.bank_sel};
        end
        flash_ctrl_pkg::ADDR_STATUS: s_next.bus.rdata = {24'h0, status_byte};
        flash_ctrl_pkg::ADDR_COMMAND: s_next.bus.rdata = {24'h0, s_reg.bank[bs].cmd};
        flash_ctrl_pkg::ADDR_PROTECT: s_next.bus.rdata = {24'h0, s_reg.prot};
        flash_ctrl_pkg::ADDR_SECURITY: begin
          s_next.bus.rdata = {24'h0, s_reg.backdoor_enable, 4'h0, s_reg.security_field};
        end
        flash_ctrl_pkg::ADDR_ARRAY_DATA: begin
          if (s_reg.key_access || !s_reg.bank[bs].cmd_complete_flag) begin
            s_next.bus.rdata = flash_ctrl_pkg::INVALID_DATA;
          end else begin
            s_next.bus.rdata = {24'h0, stored_security_byte};
          end
        end
        default: begin
          s_next.bus.rdata = 32'h0;
          s_next.bus.rresp = flash_ctrl_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.bus.rvalid && s_axi_rready) begin
      s_next.bus.rvalid = 1'b0;
    end

    // Level request from selected bank only
    s_next.irq = (s_next.buffers_empty_irq_en & s_next.bank[s_next.bank_sel].buffers_empty_flag) |
      (s_next.complete_irq_en & s_next.bank[s_next.bank_sel].cmd_complete_flag);
  end

  // Reset aborts any command and reloads security from the stored byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.eng <= flash_ctrl_pkg::ENG_LOAD;
      s_reg.prot <= flash_ctrl_pkg::PROT_RESET;
      for (int i = 0; i < NUM_BANKS_L; i++) begin
        s_reg.bank[i].buffers_empty_flag <= 1'b1;
        s_reg.bank[i].cmd_complete_flag <= 1'b1;
      end
    end else if (s_reg.eng == flash_ctrl_pkg::ENG_LOAD) begin
      // Security byte sampled after release, never under reset
      s_reg <= s_next;
      s_reg.security_field <= stored_security_byte[1:0];
      s_reg.backdoor_enable <= stored_security_byte[7:flash_ctrl_pkg::SEC_BACKDOOR_ENABLE_LO];
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end
endmodule : flash_stop_security_irq_ctrl

// ---- testbench/flash_ctrl_sva.sv ----
// Port-level assertion checker for the flash control block
`timescale 1ns/1ps
module flash_ctrl_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic background_debug_mode,
  input wire logic special_single_chip,
  input wire logic [7:0] stored_security_byte,
  input wire logic chip_secured,
  input wire logic flash_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read request steps
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_refused;
    s_rd_taken ##0 (s_axi_araddr > 8'h18);
  endsequence
  property p_bad_read;
    s_rd_refused |=> s_axi_rvalid && s_axi_rresp == 2'b10;
  endproperty
  a_bad_read: assert property (p_bad_read) else $error("unmapped read not refused");
  property p_rd_answer;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read taken while busy");
  // Security loaded from the stored byte on the first edge out of reset
  property p_sec_load;
    $rose(aresetn) |=> chip_secured == (stored_security_byte[1:0] != 2'b10);
  endproperty
  a_sec_load: assert property (p_sec_load) else $error("security not loaded");
  // Only a reset can secure the chip again
  property p_sec_sticky;
    !$rose(aresetn) && !chip_secured |=> !chip_secured;
  endproperty
  a_sec_sticky: assert property (p_sec_sticky) else $error("security changed");
  property p_ssc_refuse;
    background_debug_mode && special_single_chip && chip_secured |=> chip_secured;
  endproperty
  a_ssc_refuse: assert property (p_ssc_refuse) else $error("debug unlock taken");
  // Unlock only lands together with a write response
  property p_unlock_write;
    $fell(chip_secured) && $past(aresetn, 2) |-> $rose(s_axi_bvalid);
  endproperty
  a_unlock_write: assert property (p_unlock_write) else $error("unlock without write");
  property p_irq_reset;
    $rose(aresetn) |-> !flash_irq;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("irq high from reset");
endmodule : flash_ctrl_sva

// ---- testbench/cpu_sw_model.sv ----
// Software side: AXI4-Lite master issuing register accesses
`timescale 1ns/1ps
module cpu_sw_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Answers are always taken at once, so both ready lines stay high
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_bready, s_axi_rready} = 2'h3;
  end
  // Ready is sampled mid-cycle; it only moves after a rising edge
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    @(negedge aclk);
    while (!s_axi_bvalid) @(negedge aclk);
    r = s_axi_bresp;
    @(posedge aclk);
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(negedge aclk);
    while (!s_axi_arready) @(negedge aclk);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(negedge aclk);
    while (!s_axi_rvalid) @(negedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask : rd
endmodule : cpu_sw_model

// ---- testbench/flash_stop_security_irq_ctrl_bench.sv ----
// Self-checking bench for the flash control block
`timescale 1ns/1ps
module flash_stop_security_irq_ctrl_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic stop_req = 1'b0;
  logic background_debug_mode = 1'b0;
  logic special_single_chip = 1'b0;
  logic [7:0] stored_security_byte = 8'h80;
  logic [63:0] stored_key = 64'h0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, chip_secured, flash_irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, exp_prot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] cmds [4] = '{8'h05, 8'h20, 8'h40, 8'h41};
  int err_count = 0;
  int compares = 0;
  int seed = 95;
  flash_stop_security_irq_ctrl dut (.*);
  cpu_sw_model cpu (.*);
  always #25 aclk = ~aclk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task stop_test;
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task do_reset;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : do_reset
  // Settle after a few edges before looking at levels
  task settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : settle
  // Key access on, four words in rising order, key access off
  task unlock(input logic bad);
    cpu.wr(8'h00, 32'h10, rs);
    for (int i = 0; i < 4; i++) begin
      cpu.wr(8'h14, {16'hff00 + 16'(2 * i), stored_key[16*i+:16] ^ 16'(bad && i == 2)}, rs);
    end
    cpu.rd(8'h18, rdat, rs);
    chk(rdat, 32'hffffffff);
    cpu.wr(8'h00, 32'h0, rs);
  endtask : unlock
  task cmd(input logic [7:0] c, output logic [1:0] r);
    cpu.wr(8'h14, 32'h80000000, rs);
    cpu.wr(8'h08, {24'h0, c}, r);
    cpu.wr(8'h04, 32'h80, rs);
  endtask : cmd
  // Watchdog, well beyond the expected run length
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    stop_test;
  end
  initial begin
    stored_key = {$random(seed), $random(seed)};
    exp_prot = 8'($random(seed));
    do_reset;
    chk({31'h0, chip_secured}, 32'h1);
    cpu.rd(8'h10, rdat, rs);
    chk(rdat, 32'h80);
    cpu.rd(8'h0c, rdat, rs);
    chk(rdat, 32'hff);
    cpu.wr(8'h0c, {24'h0, exp_prot}, rs);
    chk({30'h0, rs}, 32'h2);
    background_debug_mode <= 1'b1;
    cpu.wr(8'h0c, {24'h0, exp_prot}, rs);
    cpu.rd(8'h0c, rdat, rs);
    chk(rdat, {24'h0, exp_prot});
    cpu.rd(8'h1c, rdat, rs);
    chk({rdat[29:0], rs}, 32'h2);
    // Secured special mode: backdoor refused, only whole erase
    special_single_chip <= 1'b1;
    unlock(1'b0);
    chk({31'h0, chip_secured}, 32'h1);
    cmd(8'h20, rs);
    chk({30'h0, rs}, 32'h2);
    cmd(8'h41, rs);
    cpu.rd(8'h04, rdat, rs);
    chk({rdat[6], rdat[4]}, 32'h3);
    // Keep bit 7 high: a zero there is an abort and sets the error again
    cpu.wr(8'h04, 32'h90, rs);
    cmd(8'h41, rs);
    chk({30'h0, rs}, 32'h0);
    settle(20);
    special_single_chip <= 1'b0;
    background_debug_mode <= 1'b0;
    unlock(1'b1);
    chk({31'h0, chip_secured}, 32'h1);
    unlock(1'b0);
    chk({31'h0, chip_secured}, 32'h0);
    cpu.rd(8'h10, rdat, rs);
    chk(rdat, 32'h82);
    cpu.rd(8'h0c, rdat, rs);
    chk(rdat, {24'h0, exp_prot});
    background_debug_mode <= 1'b1;
    foreach (cmds[i]) begin
      cmd(cmds[i], rs);
      chk({30'h0, rs}, 32'h0);
      cpu.rd(8'h04, rdat, rs);
      chk({31'h0, rdat[6]}, 32'h0);
      settle(20);
      cpu.rd(8'h04, rdat, rs);
      chk({31'h0, rdat[6]}, 32'h1);
    end
    // Interrupt follows flags and enables as a level
    cpu.wr(8'h00, 32'h40, rs);
    settle(2);
    chk({31'h0, flash_irq}, 32'h1);
    cmd(8'h20, rs);
    settle(2);
    chk({31'h0, flash_irq}, 32'h0);
    settle(20);
    chk({31'h0, flash_irq}, 32'h1);
    cpu.wr(8'h00, 32'h80, rs);
    settle(2);
    chk({31'h0, flash_irq}, 32'h1);
    cpu.wr(8'h00, 32'h0, rs);
    settle(2);
    chk({31'h0, flash_irq}, 32'h0);
    // Stop in mid-command, then leave stop
    cmd(8'h20, rs);
    stop_req <= 1'b1;
    settle(8);
    cpu.rd(8'h04, rdat, rs);
    chk({rdat[6], rdat[4]}, 32'h3);
    stop_req <= 1'b0;
    settle(8);
    cpu.rd(8'h04, rdat, rs);
    chk({31'h0, rdat[7]}, 32'h1);
    cpu.wr(8'h04, 32'h90, rs);
    // Reset in mid-command re-reads the stored byte
    cmd(8'h20, rs);
    do_reset;
    chk({31'h0, chip_secured}, 32'h1);
    cpu.rd(8'h04, rdat, rs);
    chk({31'h0, rdat[6]}, 32'h1);
    stored_security_byte <= 8'h02;
    do_reset;
    chk({31'h0, chip_secured}, 32'h0);
    stop_test;
  end
endmodule : flash_stop_security_irq_ctrl_bench
bind flash_stop_security_irq_ctrl flash_ctrl_sva sva_i (.*);
